// file: src/adcsf_pkg.sv
/*
  Shared constants for the converter's state control and serial frame logic:
  timing figures and derived cycle counts, frame layout, the state encoding.
  Assumes a single 25 MHz system clock.
*/
package adcsf_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 40;

  // timing figures in ns
  localparam int CONV_TIME_NS = 1000;
  localparam int APP_EXIT_NS = 1000;
  localparam int POR_EXIT_NS = 20000;

  // least times, rounded up to whole cycles
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int APP_EXIT_CYCLES = (APP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_EXIT_CYCLES = (POR_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_W = 16;

  // frame layout
  localparam int FRAME_BITS = 32;
  localparam int COUNT_W = 8;
  localparam logic [COUNT_W-1:0] FRAME_FULL = 8'h20;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 8'hff;
  localparam logic [FRAME_BITS-1:0] NO_OPERATION = 32'h0000_0000;
  localparam logic [FRAME_BITS-1:0] FIXED_PATTERN = 32'haaaa_5555;

  // output word selection
  localparam int PATTERN_W = 3;
  localparam int PATTERN_FIXED_BIT = 2;

  // buffering
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_ACQ = 3'b010,
    ST_CONV = 3'b100
  } adcsf_state_t;

endpackage : adcsf_pkg

// file: src/adcsf_frame_ctrl.sv
/*
  Operating-state control and 32-bit serial frame handling of a sampling
  converter, plus the sample FIFO in front of the output shift register.
  Assumes host pins (select, serial clock, serial input) are asynchronous to
  clock, and that sample_data comes from converter logic on the same clock.
*/
// Overview of operation
// - three states only, chosen by convert select and the reset input.
// - reset acts asynchronously, active low; host holds it the minimum width.
// - application reset restores configuration, holds ready low, tri-states lanes.
// - default power-on reset clears everything; host waits the settling delay.
// - exit reset with select and clock low; after delay enter acquisition, ready high.
// - acquisition entered at power-up, after reset and after every conversion.
// - reset falling edge moves acquisition to reset.
// - select rising edge in acquisition starts a conversion.
// - conversion runs on internal timing; select transitions ignored meanwhile.
// - frame spans select low to next rise; begins only after conversion.
// - frame start drops ready, clears count, takes lanes, loads output word.
// - frame start clears the command register to no-operation.
// - each capture edge counts and shifts input bit into the LSB.
// - each launch edge puts the output register MSB on selected lanes.
// - frame end tri-states lanes, passes command, drops ready for conversion.
// - count of exactly 32 makes the shifted word a valid command.
// - count below 32 discards the write, acting as no-operation.
// - short frame output bits stay valid leading data.
// - count above 32 uses the last 32 bits shifted in.
// - no upper limit on serial clocks per frame.
// - a valid command takes effect at the rising edge ending its frame.
// - output word depends on previous frame's command and pattern select.
`timescale 1ns/1ps

module adcsf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] wr_nxt;
  logic [AW:0] rd_r;
  logic [AW:0] rd_nxt;
  logic push;
  logic pop;

  always_comb begin
    in_ready = (wr_r - rd_r) != (AW + 1)'(DEPTH);
    out_valid = wr_r != rd_r;
    out_data = mem[rd_r[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  // storage has no reset; contents are only read when out_valid
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

endmodule : adcsf_fifo

module adcsf_frame_ctrl
  import adcsf_pkg::*;
#(
  parameter int LANES = 2,
  parameter int CONV_CYC = adcsf_pkg::CONV_CYCLES,
  parameter int APP_EXIT_CYC = adcsf_pkg::APP_EXIT_CYCLES,
  parameter int POR_EXIT_CYC = adcsf_pkg::POR_EXIT_CYCLES
) (
  // clock and the documented reset input
  input wire logic clock,
  input wire logic reset_n,
  // host pins
  input wire logic convert_select_n,
  input wire logic serial_clock,
  input wire logic serial_in,
  output logic ready_strobe,
  output logic [LANES-1:0] serial_out_lanes,
  output logic [LANES-1:0] serial_out_lanes_oe_n,
  // configuration levels
  input wire logic app_reset_select,
  input wire logic capture_on_fall,
  input wire logic [LANES-1:0] lane_select,
  input wire logic [adcsf_pkg::PATTERN_W-1:0] output_pattern_select,
  // converter side
  input wire logic [adcsf_pkg::FRAME_BITS-1:0] sample_data,
  output logic sample_ready,
  // command processor side
  output logic [adcsf_pkg::FRAME_BITS-1:0] command_word,
  output logic command_valid,
  output logic [adcsf_pkg::COUNT_W-1:0] frame_clock_count,
  output logic [2:0] device_state
);
  import adcsf_pkg::*;

  // pin synchronisers: stage 1 is read only by stage 2
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic cs_prev_r;
  logic sck_prev_r;
  logic cs_s;
  logic sck_s;
  logic sdi_s;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      // idle pin levels, so no false serial clock edge follows reset
      sync1_r <= 3'h4;
      sync2_r <= 3'h4;
      cs_prev_r <= 1'b1;
      sck_prev_r <= 1'b0;
    end else begin
      sync1_r <= {convert_select_n, serial_clock, serial_in};
      sync2_r <= sync1_r;
      cs_prev_r <= sync2_r[2];
      sck_prev_r <= sync2_r[1];
    end
  end

  assign cs_s = sync2_r[2];
  assign sck_s = sync2_r[1];
  assign sdi_s = sync2_r[0];

  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic capture_edge;
  logic launch_edge;

  always_comb begin
    cs_fall = cs_prev_r && !cs_s;
    cs_rise = !cs_prev_r && cs_s;
    sck_rise = !sck_prev_r && sck_s;
    sck_fall = sck_prev_r && !sck_s;
    capture_edge = capture_on_fall ? sck_fall : sck_rise;
    launch_edge = capture_on_fall ? sck_rise : sck_fall;
  end

  // sample buffer between converter and output shift register
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [FRAME_BITS-1:0] fifo_out_data;

  // state, frame and shift registers
  adcsf_state_t state_r;
  adcsf_state_t state_nxt;
  logic frame_r;
  logic frame_nxt;
  logic ready_r;
  logic ready_nxt;
  logic [DELAY_W-1:0] delay_r;
  logic [DELAY_W-1:0] delay_nxt;
  logic app_sel_r;
  logic app_sel_nxt;
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic [FRAME_BITS-1:0] isr_r;
  logic [FRAME_BITS-1:0] isr_nxt;
  logic [FRAME_BITS-1:0] osr_r;
  logic [FRAME_BITS-1:0] osr_nxt;
  logic [FRAME_BITS-1:0] cmd_r;
  logic [FRAME_BITS-1:0] cmd_nxt;
  logic [FRAME_BITS-1:0] prev_cmd_r;
  logic [FRAME_BITS-1:0] prev_cmd_nxt;
  logic cmd_valid_r;
  logic cmd_valid_nxt;
  logic drive_r;
  logic drive_nxt;
  logic [FRAME_BITS-1:0] out_word;
  logic [DELAY_W-1:0] exit_lim;

  always_comb begin
    exit_lim = app_sel_r ? DELAY_W'(APP_EXIT_CYC) : DELAY_W'(POR_EXIT_CYC);
    // previous command selects the word; the fixed pattern overrides it
    if (output_pattern_select[PATTERN_FIXED_BIT]) begin
      out_word = FIXED_PATTERN;
    end else if (prev_cmd_r != NO_OPERATION) begin
      out_word = {prev_cmd_r[15:0], 16'h0000};
    end else if (fifo_out_valid) begin
      out_word = fifo_out_data;
    end else begin
      out_word = '0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    frame_nxt = frame_r;
    ready_nxt = ready_r;
    delay_nxt = delay_r;
    app_sel_nxt = app_sel_r;
    count_nxt = count_r;
    isr_nxt = isr_r;
    osr_nxt = osr_r;
    cmd_nxt = cmd_r;
    prev_cmd_nxt = prev_cmd_r;
    cmd_valid_nxt = 1'b0;
    drive_nxt = drive_r;
    fifo_pop = 1'b0;
    case (state_r)
      ST_RESET: begin
        ready_nxt = 1'b0;
        drive_nxt = 1'b0;
        app_sel_nxt = app_reset_select;
        // exit delay only runs while select and clock stay low
        if (cs_s || sck_s) begin
          delay_nxt = '0;
        end else if (delay_r >= exit_lim - 1'b1) begin
          state_nxt = ST_ACQ;
          ready_nxt = 1'b1;
          delay_nxt = '0;
        end else begin
          delay_nxt = delay_r + 1'b1;
        end
      end
      ST_ACQ: begin
        if (cs_fall && !frame_r) begin
          frame_nxt = 1'b1;
          ready_nxt = 1'b0;
          count_nxt = '0;
          drive_nxt = 1'b1;
          osr_nxt = out_word;
          cmd_nxt = NO_OPERATION;
          fifo_pop = !output_pattern_select[PATTERN_FIXED_BIT] && prev_cmd_r == NO_OPERATION;
        end else if (cs_rise) begin
          state_nxt = ST_CONV;
          frame_nxt = 1'b0;
          ready_nxt = 1'b0;
          drive_nxt = 1'b0;
          delay_nxt = '0;
          if (frame_r && count_r >= FRAME_FULL) begin
            cmd_nxt = isr_r;
            cmd_valid_nxt = 1'b1;
            prev_cmd_nxt = isr_r;
          end else if (frame_r) begin
            cmd_nxt = NO_OPERATION;
            prev_cmd_nxt = NO_OPERATION;
          end
        end else if (frame_r) begin
          if (capture_edge) begin
            // saturating count: any frame length is accepted
            if (count_r != COUNT_MAX) begin
              count_nxt = count_r + 1'b1;
            end
            isr_nxt = {isr_r[FRAME_BITS-2:0], sdi_s};
          end
          if (launch_edge) begin
            osr_nxt = {osr_r[FRAME_BITS-2:0], 1'b0};
          end
        end
      end
      ST_CONV: begin
        // select pin is not looked at here
        ready_nxt = 1'b0;
        if (delay_r >= DELAY_W'(CONV_CYC - 1)) begin
          // a full buffer drops the sample; only a frame drains it, so stalling would never end
          state_nxt = ST_ACQ;
          ready_nxt = 1'b1;
          delay_nxt = '0;
        end else begin
          delay_nxt = delay_r + 1'b1;
        end
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
  end

  // asynchronous reset enters the reset state from any state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_RESET;
      frame_r <= 1'b0;
      ready_r <= 1'b0;
      delay_r <= '0;
      app_sel_r <= 1'b0;
      count_r <= '0;
      isr_r <= '0;
      osr_r <= '0;
      cmd_r <= NO_OPERATION;
      prev_cmd_r <= NO_OPERATION;
      cmd_valid_r <= 1'b0;
      drive_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      frame_r <= frame_nxt;
      ready_r <= ready_nxt;
      delay_r <= delay_nxt;
      app_sel_r <= app_sel_nxt;
      count_r <= count_nxt;
      isr_r <= isr_nxt;
      osr_r <= osr_nxt;
      cmd_r <= cmd_nxt;
      prev_cmd_r <= prev_cmd_nxt;
      cmd_valid_r <= cmd_valid_nxt;
      drive_r <= drive_nxt;
    end
  end

  logic conv_done;
  assign conv_done = state_r == ST_CONV && state_nxt == ST_ACQ;

  adcsf_fifo #(
    .WIDTH(FRAME_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(conv_done),
    .in_ready(fifo_in_ready),
    .in_data(sample_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // per-lane output flops, oe_n low while driving
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic lane_r;
      logic lane_nxt;
      logic oe_n_r;
      logic oe_n_nxt;
      always_comb begin
        lane_nxt = osr_nxt[FRAME_BITS-1];
        oe_n_nxt = !(drive_nxt && lane_select[g]);
      end
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          lane_r <= 1'b0;
          oe_n_r <= 1'b1;
        end else begin
          lane_r <= lane_nxt;
          oe_n_r <= oe_n_nxt;
        end
      end
      assign serial_out_lanes[g] = lane_r;
      assign serial_out_lanes_oe_n[g] = oe_n_r;
    end
  endgenerate

  logic sample_ready_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sample_ready_r <= 1'b0;
    end else begin
      sample_ready_r <= fifo_in_ready;
    end
  end

  assign ready_strobe = ready_r;
  assign command_word = cmd_r;
  assign command_valid = cmd_valid_r;
  assign frame_clock_count = count_r;
  assign device_state = state_r;
  assign sample_ready = sample_ready_r;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_frame_open;
    state_r == ST_ACQ && !frame_r && cs_fall;
  endsequence

  sequence s_frame_close;
    state_r == ST_ACQ && frame_r && cs_rise;
  endsequence

  a_ready_in_reset: assert property (state_r == ST_RESET |-> !ready_strobe)
    else $error("ready high in reset");
  a_frame_start_outs: assert property (s_frame_open |=> !ready_strobe && count_r == '0 && drive_r)
    else $error("frame start outputs wrong");
  a_frame_cmd_clear: assert property (s_frame_open |=> command_word == NO_OPERATION)
    else $error("command not cleared at frame start");
  a_capture_count: assert property (state_r == ST_ACQ && frame_r && capture_edge && !cs_rise && !cs_fall
      && count_r != COUNT_MAX |=> count_r == $past(count_r) + 1'b1 && isr_r[0] == $past(sdi_s))
    else $error("capture edge not counted");
  a_launch_msb: assert property (state_r == ST_ACQ && frame_r && launch_edge && !cs_rise && !cs_fall
      |=> serial_out_lanes[0] == $past(osr_r[FRAME_BITS-2]))
    else $error("launch edge did not shift");
  a_end_tristate: assert property (s_frame_close |=> &serial_out_lanes_oe_n && !ready_strobe
      && state_r == ST_CONV)
    else $error("frame end outputs wrong");
  a_valid_command: assert property (s_frame_close ##0 (count_r >= FRAME_FULL) |=> command_valid
      && command_word == $past(isr_r))
    else $error("full frame command lost");
  a_short_nop: assert property (s_frame_close ##0 (count_r < FRAME_FULL) |=> !command_valid
      && command_word == NO_OPERATION)
    else $error("short frame not a no-operation");
  a_conv_hold: assert property (state_r == ST_CONV && delay_r < DELAY_W'(CONV_CYC - 1)
      |=> state_r == ST_CONV && !ready_strobe)
    else $error("conversion cut short");
  a_conv_to_acq: assert property ($fell(state_r == ST_CONV) |-> state_r == ST_ACQ && ready_strobe
      && $past(delay_r) >= DELAY_W'(CONV_CYC - 1))
    else $error("conversion end wrong");
  a_conv_ends: assert property (state_r == ST_CONV && delay_r >= DELAY_W'(CONV_CYC - 1)
      |=> state_r == ST_ACQ && ready_strobe)
    else $error("conversion did not end on time");

endmodule : adcsf_frame_ctrl

// file: test/adcsf_host.sv
/*
  Host controller model for the converter's frame port: drives select,
  serial clock and serial input, and collects the first driven output lane.
  Assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/1ps
module adcsf_host (
  // clock
  input wire logic clock,
  // device answers
  input wire logic ready_strobe,
  input wire logic serial_out_lane,
  // host pins
  output logic convert_select_n,
  output logic serial_clock,
  output logic serial_in,
  // frame window for the bench monitor
  output logic mid
);
  initial begin
    convert_select_n = 1'b0;
    serial_clock = 1'b0;
    serial_in = 1'b0;
    mid = 1'b0;
  end

  // select and clock low so the device may leave reset
  task automatic park();
    @(posedge clock);
    convert_select_n <= 1'b0;
    serial_clock <= 1'b0;
  endtask : park

  // n clocks, bits sent msb first from din[n-1:0]; glitch toggles select in conversion
  task automatic frame(input int n, input logic [511:0] din, input bit glitch, output logic [31:0] dout);
    int i;
    int k;
    // a rise with no frame open is a bare conversion, needed to get a fall
    if (convert_select_n === 1'b0) begin
      @(posedge clock);
      convert_select_n <= 1'b1;
      repeat (6) @(posedge clock);
    end
    for (k = 0; k < 200 && ready_strobe !== 1'b1; k++) @(posedge clock);
    @(posedge clock);
    convert_select_n <= 1'b0;
    dout = '0;
    repeat (6) @(posedge clock);
    mid <= 1'b1;
    for (i = 0; i < n; i++) begin
      if (i < 32) dout[31-i] = serial_out_lane;
      serial_in <= din[n-1-i];
      repeat (3) @(posedge clock);
      serial_clock <= 1'b1;
      repeat (5) @(posedge clock);
      serial_clock <= 1'b0;
      repeat (5) @(posedge clock);
    end
    // window stays up through one edge even when no clocks are sent
    @(posedge clock);
    mid <= 1'b0;
    convert_select_n <= 1'b1;
    if (glitch) begin
      repeat (3) @(posedge clock);
      convert_select_n <= 1'b0;
      repeat (3) @(posedge clock);
      convert_select_n <= 1'b1;
    end
  endtask : frame
endmodule : adcsf_host

// file: test/test_adc_state_and_serial_frame.sv
/*
  Self-checking bench for the frame controller: a queue model of the sample
  FIFO and of the previous command predicts every output word and command.
  Assumes the host model in adcsf_host and shortened delay counts.
*/
`timescale 1ns/1ps
module test_adc_state_and_serial_frame;
  import adcsf_pkg::*;
  localparam int CONV = 12;
  localparam int APP_EXIT = 4;
  localparam int POR_EXIT = 20;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic app_reset_select = 1'b1;
  logic capture_on_fall = 1'b0;
  logic [1:0] lane_select = 2'b11;
  logic [2:0] output_pattern_select = 3'h0;
  logic [31:0] sample_data = 32'h0;
  wire logic convert_select_n, serial_clock, serial_in, host_mid, ready_strobe, sample_ready, command_valid;
  wire logic [1:0] serial_out_lanes, serial_out_lanes_oe_n;
  wire logic [31:0] command_word;
  wire logic [7:0] frame_clock_count;
  wire logic [2:0] device_state;
  // host reads the first driven lane; a released line reads back inverted
  wire logic host_lane;
  assign host_lane = !serial_out_lanes_oe_n[0] ? serial_out_lanes[0] :
    !serial_out_lanes_oe_n[1] ? serial_out_lanes[1] : ~serial_out_lanes[0];
  int seed = 32'h189d;
  int error_cnt = 0;
  int n_tests = 0;
  logic [31:0] q[$];
  logic [31:0] prev = '0;
  logic cap_valid = 1'b0;
  logic mid_d = 1'b0;
  logic [7:0] last_cnt = 8'h0;

  always #20 clock = ~clock;

  adcsf_frame_ctrl #(.LANES(2), .CONV_CYC(CONV), .APP_EXIT_CYC(APP_EXIT), .POR_EXIT_CYC(POR_EXIT)) i_dut (
    .clock(clock), .reset_n(reset_n), .convert_select_n(convert_select_n), .serial_clock(serial_clock),
    .serial_in(serial_in), .ready_strobe(ready_strobe), .serial_out_lanes(serial_out_lanes),
    .serial_out_lanes_oe_n(serial_out_lanes_oe_n), .app_reset_select(app_reset_select),
    .capture_on_fall(capture_on_fall), .lane_select(lane_select), .output_pattern_select(output_pattern_select),
    .sample_data(sample_data), .sample_ready(sample_ready), .command_word(command_word),
    .command_valid(command_valid), .frame_clock_count(frame_clock_count), .device_state(device_state));

  adcsf_host i_host (.clock(clock), .ready_strobe(ready_strobe), .serial_out_lane(host_lane),
    .convert_select_n(convert_select_n), .serial_clock(serial_clock), .serial_in(serial_in), .mid(host_mid));

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_flag(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %b, seen %b", nm, e, g);
    end
  endtask : chk_flag

  task automatic give_verdict();
    $display("errors %0d, checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // frame window monitor
  always @(posedge clock) begin
    if (command_valid === 1'b1) cap_valid <= 1'b1;
    mid_d <= host_mid;
    if (host_mid) begin
      last_cnt <= frame_clock_count;
      chk_word("lane enables", {30'h0, ~lane_select}, {30'h0, serial_out_lanes_oe_n});
      chk_flag("ready in frame", 1'b0, ready_strobe);
      if (lane_select == 2'b11) chk_flag("second lane", serial_out_lanes[0], serial_out_lanes[1]);
      if (!mid_d) begin
        chk_word("count at start", 32'h0, {24'h0, frame_clock_count});
        chk_word("command at start", NO_OPERATION, command_word);
      end
    end
  end

  task automatic do_reset(input bit app);
    int k;
    @(posedge clock);
    app_reset_select <= app;
    reset_n <= 1'b0;
    #1;
    chk_word("state in reset", {29'h0, ST_RESET}, {29'h0, device_state});
    chk_flag("ready in reset", 1'b0, ready_strobe);
    chk_word("lanes in reset", 32'h3, {30'h0, serial_out_lanes_oe_n});
    chk_word("command in reset", 32'h0, command_word);
    i_host.park();
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    for (k = 0; k < 80 && ready_strobe !== 1'b1; k++) @(posedge clock);
    chk_flag("exit delay", 1'b1,
      app ? (k >= APP_EXIT && k <= APP_EXIT + 8) : (k >= POR_EXIT && k < 80));
    #1;
    chk_word("state after exit", {29'h0, ST_ACQ}, {29'h0, device_state});
    q.delete();
    prev = '0;
  endtask : do_reset

  task automatic do_frame(input int n, input bit fm, input bit gl, input logic [2:0] pat, input logic [1:0] ls);
    logic [511:0] din;
    logic [31:0] s, e, got, mask;
    int k;
    for (k = 0; k < 16; k++) din[k*32 +: 32] = $random(seed);
    s = $random(seed);
    @(posedge clock);
    capture_on_fall <= fm;
    output_pattern_select <= pat;
    lane_select <= ls;
    sample_data <= s;
    if (i_host.convert_select_n === 1'b0) q.push_back(s);
    if (pat[2]) e = FIXED_PATTERN;
    else if (prev != 0) e = {prev[15:0], 16'h0};
    else if (q.size() > 0) e = q.pop_front();
    else e = '0;
    mask = (n >= 32) ? '1 : ~(32'hffff_ffff >> n);
    cap_valid = 1'b0;
    i_host.frame(n, din, gl, got);
    chk_word("output word", e & mask, got & mask);
    repeat (5) @(posedge clock);
    #1;
    chk_word("state in conversion", {29'h0, ST_CONV}, {29'h0, device_state});
    chk_flag("ready in conversion", 1'b0, ready_strobe);
    chk_word("lanes released", 32'h3, {30'h0, serial_out_lanes_oe_n});
    for (k = 0; k < 60 && ready_strobe !== 1'b1; k++) @(posedge clock);
    chk_flag("ready after conversion", 1'b1, ready_strobe);
    repeat (8) @(posedge clock);
    #1;
    chk_word("state after conversion", {29'h0, ST_ACQ}, {29'h0, device_state});
    chk_word("lanes idle", 32'h3, {30'h0, serial_out_lanes_oe_n});
    chk_word("command word", (n >= 32) ? din[31:0] : NO_OPERATION, command_word);
    chk_flag("command valid", n >= 32, cap_valid);
    chk_word("clock count", (n > 255) ? 32'd255 : n, {24'h0, last_cnt});
    // a full buffer drops the new sample
    if (q.size() < FIFO_DEPTH) q.push_back(s);
    prev = (n >= 32) ? din[31:0] : '0;
  endtask : do_frame

  initial begin
    do_reset(1'b1);
    chk_flag("fifo not full", 1'b1, sample_ready);
    do_frame(32, 1'b0, 1'b0, 3'h0, 2'b11);
    do_frame(20, 1'b0, 1'b0, 3'h0, 2'b11);
    do_frame(40, 1'b1, 1'b0, 3'h0, 2'b11);
    do_frame(32, 1'b0, 1'b1, 3'h0, 2'b01);
    do_frame(260, 1'b0, 1'b0, 3'h4, 2'b10);
    // fill with pattern frames, which leave the samples queued
    while (q.size() < FIFO_DEPTH) do_frame(0, 1'b0, 1'b0, 3'h4, 2'b11);
    repeat (3) @(posedge clock);
    chk_flag("fifo full", 1'b0, sample_ready);
    // a conversion into a full buffer must still end on time
    do_frame(0, 1'b0, 1'b0, 3'h4, 2'b11);
    repeat (FIFO_DEPTH) do_frame(16, 1'b0, 1'b0, 3'h3, 2'b11);
    do_reset(1'b0);
    do_frame(32, 1'b0, 1'b0, 3'h0, 2'b11);
    give_verdict();
  end

  // cut a hang well beyond the expected run of some 14000 cycles
  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    give_verdict();
  end
endmodule : test_adc_state_and_serial_frame
